// ===== logic/dmac_slice.sv
// Cascadable multiply / accumulate / ALU slice with AXI4-Lite configuration.
// Assumes operands and dynamic controls come from logic on MCLK, with
// CLK_TICK standing in for the four selectable clock sources.
// Notes on behaviour
// - One 18x36, two 18x18 or four 9x9 products
// - Two cascaded slices form a 36x36 product
// - Accumulated result holds up to 54 bits
// - Dual products accumulate in one cycle, 52 bits
// - ALU opcode may change every cycle
// - Three operands added or subtracted together
// - Bitwise AND, OR, NAND, NOR, XOR, XNOR
// - Eight flag outputs for pattern detection
// - Synchronous stage resets, asynchronous RESETN, legacy immediate reset option
// - Datapath selections driven dynamically each cycle
// - Element capacity per slice by width
// - Sum tree at 9 bits uses half slice
// - Input register loads parallel or shifts in
// - Add or subtract chosen each cycle
// - Parallel or serial operand loading chosen dynamically
// - Product element: product only, optional registers
// - Accumulate element: running total, output register forced
// - Accumulator loadable at run time, registered overflow
// - Dual accumulate adds both products and total
// - Product sum adds or subtracts two products
// - Sum tree adds cascade result in second slice
// - Two slices reproduce one legacy arithmetic block
// - Zero, mask, pattern, over, under, combined flags
// - Each stage picks clock, enable, reset source
`timescale 1ns/100ps
`default_nettype none
module dmac_slice
  import dmac_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                MCLK,
  input  wire logic                RESETN,
  // AXI4-Lite register port
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  // Stage clock sources, enables and resets
  input  wire logic [3:0]          CLK_TICK,
  input  wire logic [3:0]          STAGE_CE,
  input  wire logic [3:0]          STAGE_RST,
  // Dynamic controls
  input  wire logic [3:0]          OPCODE,
  input  wire logic [1:0]          ADDSUB,
  input  wire logic                LOAD_SHIFT,
  input  wire logic                ACC_LOAD,
  input  wire logic [RES_W-1:0]    ACC_INIT,
  // Operands
  input  wire logic [OPS_W-1:0]    OPERAND_A_FIRST,
  input  wire logic [OPL_W-1:0]    OPERAND_A_SECOND,
  input  wire logic [OPS_W-1:0]    OPERAND_B_FIRST,
  input  wire logic [OPS_W-1:0]    OPERAND_B_SECOND,
  // Operand shift chain
  input  wire logic [OPS_W-1:0]    SHIFT_IN_A_FIRST,
  input  wire logic [OPL_W-1:0]    SHIFT_IN_A_SECOND,
  input  wire logic [OPS_W-1:0]    SHIFT_IN_B_FIRST,
  input  wire logic [OPS_W-1:0]    SHIFT_IN_B_SECOND,
  output logic [OPS_W-1:0]         SHIFT_OUT_A_FIRST,
  output logic [OPL_W-1:0]         SHIFT_OUT_A_SECOND,
  output logic [OPS_W-1:0]         SHIFT_OUT_B_FIRST,
  output logic [OPS_W-1:0]         SHIFT_OUT_B_SECOND,
  // Cascade
  input  wire logic [RES_W-1:0]    CASC_IN,
  output logic [RES_W-1:0]         CASC_OUT,
  // Results
  output logic [RES_W-1:0]         RESULT,
  output logic [PROD_W-1:0]        PRODUCT,
  output logic [7:0]               FLAGS
);

  function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
    return v[s];
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  logic [31:0]       cfg_reg;
  logic [31:0]       stage_reg;
  logic [31:0]       pat_lo_reg;
  logic [31:0]       pat_hi_reg;
  logic [31:0]       mask_lo_reg;
  logic [31:0]       mask_hi_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic              wr_fire;
  logic              rd_fire;

  dmac_elem_e        elem;
  dmac_width_e       wmode;
  dmac_op_e          op_sel;
  logic [1:0]        addsub_sel;
  logic              shift_sel;
  logic              legacy;
  logic              acc_el;
  logic [RES_W-1:0]  pattern;
  logic [RES_W-1:0]  mask;

  logic [NSTAGE-1:0] en;
  logic [NSTAGE-1:0] upd;
  logic [NSTAGE-1:0] clr;
  logic [NSTAGE-1:0] kill;

  logic [OPS_W-1:0]  a1_reg, b1_reg, b2_reg;
  logic [OPL_W-1:0]  a2_reg;
  logic [OPS_W-1:0]  a1_v, b1_v, b2_v;
  logic [OPL_W-1:0]  a2_v;
  logic [RES_W-1:0]  p_long;
  logic [35:0]       p_a18, p_b18;
  logic [17:0]       p_a9h, p_a9l, p_b9h, p_b9l;
  logic [RES_W-1:0]  pa_next, pa_reg, pa_v;
  logic [35:0]       pb_next, pb_reg, pb_v;

  logic [RES_W-1:0]  alu_x, alu_y, alu_z;
  logic signed [56:0] sum_s;
  logic [RES_W-1:0]  alu_res;
  logic              over_c, under_c;
  logic [RES_W-1:0]  out_next;
  logic [7:0]        flags_next;
  logic [PROD_W-1:0] prod_next;
  logic [RES_W-1:0]  res_reg;
  logic [7:0]        flags_reg;
  logic [PROD_W-1:0] prod_reg;

  // Configuration decode
  assign elem    = dmac_elem_e'(cfg_reg[CFG_ELEM_LSB +: 3]);
  assign wmode   = dmac_width_e'(cfg_reg[CFG_WIDTH_LSB +: 2]);
  assign legacy  = cfg_reg[CFG_LEGACY_BIT];
  assign acc_el  = (elem == EL_ACCUM) || (elem == EL_DUAL_ACC);
  assign pattern = {pat_hi_reg[HI_W-1:0], pat_lo_reg};
  assign mask    = {mask_hi_reg[HI_W-1:0], mask_lo_reg};
  assign op_sel  = cfg_reg[CFG_DYN_OP_BIT] ? dmac_op_e'(OPCODE)
                                           : dmac_op_e'(cfg_reg[CFG_OP_LSB +: 4]);
  assign addsub_sel = cfg_reg[CFG_DYN_ADDSUB_BIT] ? ADDSUB
                                                  : cfg_reg[CFG_ADDSUB_LSB +: 2];
  assign shift_sel  = cfg_reg[CFG_DYN_LOAD_BIT] ? LOAD_SHIFT : cfg_reg[CFG_SHIFT_BIT];

  // Per-stage clock, enable and reset selection
  for (genvar gi = 0; gi < NSTAGE; gi++) begin : g_stage
    logic [STG_FIELD_W-1:0] f;
    logic                   tick;
    logic                   rst_sel;
    assign f       = stage_reg[gi*STG_FIELD_W +: STG_FIELD_W];
    assign tick    = pick4(CLK_TICK, f[STG_CLK_LSB +: 2]);
    assign rst_sel = pick4(STAGE_RST, f[STG_RST_LSB +: 2]);
    assign en[gi]  = f[STG_EN_BIT] | ((gi == NSTAGE - 1) && acc_el);
    // Legacy mode: reset acts without a clock tick and blanks the stage at once
    assign clr[gi]  = rst_sel & (tick | legacy);
    assign kill[gi] = rst_sel & legacy;
    assign upd[gi]  = en[gi] & tick & pick4(STAGE_CE, f[STG_CE_LSB +: 2]) & ~clr[gi];
  end

  // Input stage
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      a1_reg <= '0;
      a2_reg <= '0;
      b1_reg <= '0;
      b2_reg <= '0;
    end else if (clr[0]) begin
      a1_reg <= '0;
      a2_reg <= '0;
      b1_reg <= '0;
      b2_reg <= '0;
    end else if (upd[0]) begin
      a1_reg <= shift_sel ? SHIFT_IN_A_FIRST  : OPERAND_A_FIRST;
      a2_reg <= shift_sel ? SHIFT_IN_A_SECOND : OPERAND_A_SECOND;
      b1_reg <= shift_sel ? SHIFT_IN_B_FIRST  : OPERAND_B_FIRST;
      b2_reg <= shift_sel ? SHIFT_IN_B_SECOND : OPERAND_B_SECOND;
    end
  end

  assign a1_v = kill[0] ? '0 : (en[0] ? a1_reg : OPERAND_A_FIRST);
  assign a2_v = kill[0] ? '0 : (en[0] ? a2_reg : OPERAND_A_SECOND);
  assign b1_v = kill[0] ? '0 : (en[0] ? b1_reg : OPERAND_B_FIRST);
  assign b2_v = kill[0] ? '0 : (en[0] ? b2_reg : OPERAND_B_SECOND);
  assign SHIFT_OUT_A_FIRST  = a1_reg;
  assign SHIFT_OUT_A_SECOND = a2_reg;
  assign SHIFT_OUT_B_FIRST  = b1_reg;
  assign SHIFT_OUT_B_SECOND = b2_reg;

  // Multipliers, unsigned
  assign p_long = a1_v * a2_v;
  assign p_a18  = a1_v * a2_v[OPS_W-1:0];
  assign p_b18  = b1_v * b2_v;
  assign p_a9h  = a1_v[17:9] * a2_v[17:9];
  assign p_a9l  = a1_v[8:0] * a2_v[8:0];
  assign p_b9h  = b1_v[17:9] * b2_v[17:9];
  assign p_b9l  = b1_v[8:0] * b2_v[8:0];

  always_comb begin
    case (wmode)
      WM_18X36: begin
        pa_next = p_long;
        pb_next = '0;
      end
      WM_18X18: begin
        pa_next = {18'h0_0000, p_a18};
        pb_next = p_b18;
      end
      default: begin
        // Four 9x9 lanes; the A lane pair goes to pa_next and the B lane pair to pb_next
        pa_next = {18'h0_0000, p_a9h, p_a9l};
        pb_next = {p_b9h, p_b9l};
      end
    endcase
  end

  // Pipeline stage
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pa_reg <= '0;
      pb_reg <= '0;
    end else if (clr[1]) begin
      pa_reg <= '0;
      pb_reg <= '0;
    end else if (upd[1]) begin
      pa_reg <= pa_next;
      pb_reg <= pb_next;
    end
  end

  assign pa_v = kill[1] ? '0 : (en[1] ? pa_reg : pa_next);
  assign pb_v = kill[1] ? '0 : (en[1] ? pb_reg : pb_next);

  // ALU operand routing per element
  always_comb begin
    alu_x = pa_v;
    alu_y = '0;
    alu_z = '0;
    case (elem)
      EL_PRODUCT: begin
        // Upper half of a split 36x36 adds the lower slice's carried-over part
        if (cfg_reg[CFG_CASC_BIT]) alu_z = CASC_IN >> CASC_SHIFT;
      end
      EL_ACCUM: begin
        alu_x = res_reg;
        alu_y = pa_v;
      end
      EL_DUAL_ACC: begin
        alu_x = res_reg;
        alu_y = pa_v;
        alu_z = {18'h0_0000, pb_v};
      end
      EL_PROD_SUM: begin
        alu_y = {18'h0_0000, pb_v};
      end
      EL_TREE: begin
        alu_y = {18'h0_0000, pb_v};
        alu_z = CASC_IN;
      end
      default: begin
        alu_y = '0;
      end
    endcase
  end

  always_comb begin
    logic signed [56:0] ey;
    logic signed [56:0] ez;
    ey    = $signed({3'b000, alu_y});
    ez    = $signed({3'b000, alu_z});
    sum_s = $signed({3'b000, alu_x}) + (addsub_sel[0] ? -ey : ey)
            + (addsub_sel[1] ? -ez : ez);
    over_c  = 1'b0;
    under_c = 1'b0;
    case (op_sel)
      OP_ADD3: begin
        alu_res = sum_s[RES_W-1:0];
        under_c = sum_s[56];
        if (elem == EL_DUAL_ACC) begin
          alu_res = {2'b00, sum_s[DUAL_W-1:0]};
          over_c  = !sum_s[56] && (sum_s[55:DUAL_W] != '0);
        end else begin
          over_c  = !sum_s[56] && (sum_s[55:RES_W] != '0);
        end
      end
      OP_AND:  alu_res = alu_x & alu_y;
      OP_OR:   alu_res = alu_x | alu_y;
      OP_NAND: alu_res = ~(alu_x & alu_y);
      OP_NOR:  alu_res = ~(alu_x | alu_y);
      OP_XOR:  alu_res = alu_x ^ alu_y;
      OP_XNOR: alu_res = ~(alu_x ^ alu_y);
      default: alu_res = alu_x;
    endcase
  end

  // Run-time accumulator preload replaces the ALU result
  assign out_next = (acc_el && ACC_LOAD) ? ACC_INIT : alu_res;

  always_comb begin
    flags_next[FLG_ZERO]  = (out_next == '0);
    flags_next[FLG_ZMASK] = ((out_next & ~mask) == '0);
    flags_next[FLG_OMASK] = ((out_next | mask) == {RES_W{1'b1}});
    flags_next[FLG_PAT]   = (((out_next ^ pattern) & ~mask) == '0);
    flags_next[FLG_PATB]  = (((out_next ^ ~pattern) & ~mask) == '0);
    flags_next[FLG_OVER]  = over_c && !(acc_el && ACC_LOAD);
    flags_next[FLG_UNDER] = under_c && !(acc_el && ACC_LOAD);
    flags_next[FLG_RANGE] = flags_next[FLG_OVER] | flags_next[FLG_UNDER];
  end

  assign prod_next = (wmode == WM_18X36) ? {18'h0_0000, pa_v} : {pb_v, pa_v[35:0]};

  // Output stage; holds the running total in accumulate elements
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      res_reg   <= '0;
      flags_reg <= 8'h00;
      prod_reg  <= '0;
    end else if (clr[2]) begin
      res_reg   <= '0;
      flags_reg <= 8'h00;
      prod_reg  <= '0;
    end else if (upd[2]) begin
      res_reg   <= out_next;
      flags_reg <= flags_next;
      prod_reg  <= prod_next;
    end
  end

  // Disabled stages are bypassed, so outputs may be combinational then
  assign RESULT   = kill[2] ? '0 : (en[2] ? res_reg : out_next);
  assign FLAGS    = kill[2] ? 8'h00 : (en[2] ? flags_reg : flags_next);
  assign PRODUCT  = kill[2] ? '0 : (en[2] ? prod_reg : prod_next);
  assign CASC_OUT = RESULT;

  // AXI4-Lite: address and data taken together, one transaction each way
  assign wr_fire       = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_reg;
  assign rd_fire       = S_AXI_ARVALID & ~rvalid_reg;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY  = wr_fire;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign S_AXI_RDATA   = rdata_reg;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_reg     <= CFG_RST;
      stage_reg   <= STAGE_INIT;
      pat_lo_reg  <= PAT_RST;
      pat_hi_reg  <= PAT_RST;
      mask_lo_reg <= MASK_RST;
      mask_hi_reg <= MASK_RST;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= RESP_OKAY;
      if (S_AXI_AWADDR == ADDR_CFG) begin
        cfg_reg <= strb_merge(cfg_reg, S_AXI_WDATA, S_AXI_WSTRB);
      end else if (S_AXI_AWADDR == ADDR_STAGE) begin
        stage_reg <= strb_merge(stage_reg, S_AXI_WDATA, S_AXI_WSTRB);
      end else if (S_AXI_AWADDR == ADDR_PAT_LO) begin
        pat_lo_reg <= strb_merge(pat_lo_reg, S_AXI_WDATA, S_AXI_WSTRB);
      end else if (S_AXI_AWADDR == ADDR_PAT_HI) begin
        pat_hi_reg <= strb_merge(pat_hi_reg, S_AXI_WDATA, S_AXI_WSTRB) & 32'h003F_FFFF;
      end else if (S_AXI_AWADDR == ADDR_MASK_LO) begin
        mask_lo_reg <= strb_merge(mask_lo_reg, S_AXI_WDATA, S_AXI_WSTRB);
      end else if (S_AXI_AWADDR == ADDR_MASK_HI) begin
        mask_hi_reg <= strb_merge(mask_hi_reg, S_AXI_WDATA, S_AXI_WSTRB) & 32'h003F_FFFF;
      end else if (S_AXI_AWADDR != ADDR_RES_LO && S_AXI_AWADDR != ADDR_RES_HI) begin
        bresp_reg <= RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      if (S_AXI_ARADDR == ADDR_CFG) begin
        rdata_reg <= cfg_reg;
      end else if (S_AXI_ARADDR == ADDR_STAGE) begin
        rdata_reg <= stage_reg;
      end else if (S_AXI_ARADDR == ADDR_PAT_LO) begin
        rdata_reg <= pat_lo_reg;
      end else if (S_AXI_ARADDR == ADDR_PAT_HI) begin
        rdata_reg <= pat_hi_reg;
      end else if (S_AXI_ARADDR == ADDR_MASK_LO) begin
        rdata_reg <= mask_lo_reg;
      end else if (S_AXI_ARADDR == ADDR_MASK_HI) begin
        rdata_reg <= mask_hi_reg;
      end else if (S_AXI_ARADDR == ADDR_RES_LO) begin
        rdata_reg <= RESULT[31:0];
      end else if (S_AXI_ARADDR == ADDR_RES_HI) begin
        rdata_reg <= {2'b00, FLAGS, RESULT[RES_W-1:32]};
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks
  logic [RES_W-1:0] chk_acc;
  assign chk_acc = res_reg + alu_y;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  a_acc_running_sum: assert property (
    (elem == EL_ACCUM && upd[2] && !ACC_LOAD && op_sel == OP_ADD3 && addsub_sel == 2'b00)
    |=> res_reg == $past(chk_acc))
    else $error("accumulator did not add product to total");
  a_acc_preload: assert property (
    (acc_el && upd[2] && ACC_LOAD) |=> (res_reg == $past(ACC_INIT) && !flags_reg[FLG_OVER]))
    else $error("accumulator preload value not taken");
  a_acc_hold_ce: assert property (
    (!upd[2] && !clr[2]) |=> $stable(res_reg) && $stable(flags_reg))
    else $error("output stage changed without enable");
  a_dual_width: assert property (
    (elem == EL_DUAL_ACC && upd[2] && !ACC_LOAD && op_sel == OP_ADD3)
    |=> res_reg[RES_W-1:DUAL_W] == 2'b00)
    else $error("dual accumulate exceeded its width");
  a_bitwise_xor: assert property (
    (op_sel == OP_XOR) |-> alu_res == (alu_x ^ alu_y) && !over_c)
    else $error("xor result wrong");
  a_shift_load: assert property (
    (upd[0] && shift_sel) |=> a1_reg == $past(SHIFT_IN_A_FIRST)
                             && b2_reg == $past(SHIFT_IN_B_SECOND))
    else $error("shift load missed previous slice operand");
  a_sync_clear: assert property (
    clr[2] |=> res_reg == '0 && flags_reg == 8'h00)
    else $error("selected reset did not clear output stage");
  a_zero_latency: assert property (
    (en == 3'b000 && elem == EL_PRODUCT && !cfg_reg[CFG_CASC_BIT] && op_sel == OP_ADD3
     && wmode == WM_18X36 && kill == 3'b000)
    |-> RESULT == OPERAND_A_FIRST * OPERAND_A_SECOND)
    else $error("bypassed product not immediate");
  a_range_flag: assert property (
    upd[2] |=> flags_reg[FLG_RANGE] == (flags_reg[FLG_OVER] | flags_reg[FLG_UNDER]))
    else $error("combined range flag mismatch");
  a_write_resp_held: assert property (
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");

  c_mac_overflow: cover property (elem == EL_ACCUM && upd[2] && over_c);
  c_tree_subtract: cover property (elem == EL_TREE && addsub_sel == 2'b01 && upd[2]);
  c_op_switch: cover property (op_sel == OP_ADD3 ##1 op_sel == OP_AND);
  c_legacy_reset: cover property (kill[2]);

endmodule
`default_nettype wire

// ===== logic/dmac_pkg.sv
// Constants, field layouts and types shared by the multiply-accumulate slice.
// Assumes a 200 MHz single clock domain and an AXI4-Lite register port.
`default_nettype none
package dmac_pkg;
  // Datapath widths
  localparam int RES_W      = 54;
  localparam int DUAL_W     = 52;
  localparam int OPS_W      = 18;
  localparam int OPL_W      = 36;
  localparam int PROD_W     = 72;
  localparam int CASC_SHIFT = 18;
  localparam int NSTAGE     = 3;

  typedef enum logic [2:0] {
    EL_PRODUCT  = 3'b000,
    EL_ACCUM    = 3'b001,
    EL_DUAL_ACC = 3'b010,
    EL_PROD_SUM = 3'b011,
    EL_TREE     = 3'b100
  } dmac_elem_e;

  typedef enum logic [1:0] {
    WM_18X36 = 2'b00,
    WM_18X18 = 2'b01,
    WM_9X9   = 2'b10
  } dmac_width_e;

  typedef enum logic [3:0] {
    OP_ADD3 = 4'h0,
    OP_AND  = 4'h1,
    OP_OR   = 4'h2,
    OP_NAND = 4'h3,
    OP_NOR  = 4'h4,
    OP_XOR  = 4'h5,
    OP_XNOR = 4'h6
  } dmac_op_e;

  // Register byte addresses
  localparam logic [7:0] ADDR_CFG     = 8'h00;
  localparam logic [7:0] ADDR_STAGE   = 8'h04;
  localparam logic [7:0] ADDR_PAT_LO  = 8'h08;
  localparam logic [7:0] ADDR_PAT_HI  = 8'h0C;
  localparam logic [7:0] ADDR_MASK_LO = 8'h10;
  localparam logic [7:0] ADDR_MASK_HI = 8'h14;
  localparam logic [7:0] ADDR_RES_LO  = 8'h18;
  localparam logic [7:0] ADDR_RES_HI  = 8'h1C;

  // Configuration fields
  localparam int CFG_ELEM_LSB       = 0;
  localparam int CFG_WIDTH_LSB      = 3;
  localparam int CFG_LEGACY_BIT     = 5;
  localparam int CFG_CASC_BIT       = 6;
  localparam int CFG_DYN_ADDSUB_BIT = 8;
  localparam int CFG_ADDSUB_LSB     = 9;
  localparam int CFG_DYN_LOAD_BIT   = 11;
  localparam int CFG_SHIFT_BIT      = 12;
  localparam int CFG_OP_LSB         = 13;
  localparam int CFG_DYN_OP_BIT     = 17;
  localparam int STG_FIELD_W        = 8;
  localparam int STG_EN_BIT         = 0;
  localparam int STG_CLK_LSB        = 1;
  localparam int STG_CE_LSB         = 3;
  localparam int STG_RST_LSB        = 5;
  localparam int HI_W               = 22;
  localparam int RES_HI_FLAG_LSB    = 22;

  localparam logic [31:0] CFG_RST   = 32'h0002_0900;
  // Not named after the STAGE_RST port, which would hide it inside the slice
  localparam logic [31:0] STAGE_INIT = 32'h0001_0101;
  localparam logic [31:0] PAT_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST  = 32'h0000_0000;

  // Flag bit positions
  localparam int FLG_ZERO  = 0;
  localparam int FLG_ZMASK = 1;
  localparam int FLG_OMASK = 2;
  localparam int FLG_PAT   = 3;
  localparam int FLG_PATB  = 4;
  localparam int FLG_OVER  = 5;
  localparam int FLG_UNDER = 6;
  localparam int FLG_RANGE = 7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ===== dv/dmac_fabric.sv
// Fabric model: previous slice's operand registers and cascade feed.
// Assumes the bench loads it by non-blocking assignment on MCLK.
`timescale 1ns/100ps
`default_nettype none
module dmac_fabric
  import dmac_pkg::*;
(
  // Clock and bench values
  input  wire logic             clk,
  input  wire logic [OPS_W-1:0] load_val,
  input  wire logic [RES_W-1:0] casc_val,
  // Toward the slice
  output logic [OPS_W-1:0]      shift_a1,
  output logic [OPL_W-1:0]      shift_a2,
  output logic [OPS_W-1:0]      shift_b1,
  output logic [OPS_W-1:0]      shift_b2,
  output logic [RES_W-1:0]      casc
);
  // Registered like a real neighbour, so data lags one edge
  always_ff @(posedge clk) begin
    shift_a1 <= load_val;
    shift_a2 <= {load_val, ~load_val};
    shift_b1 <= ~load_val;
    shift_b2 <= load_val;
  end
  assign casc = casc_val;
endmodule
`default_nettype wire

// ===== dv/tb_dmac_slice.sv
// Self-checking bench for the multiply-accumulate slice.
// Assumes dmac_fabric feeds the shift chain and cascade input.
`timescale 1ns/100ps
`default_nettype none
module tb_dmac_slice;
  import dmac_pkg::*;
  typedef struct packed {
    logic [31:0] cfg;
    logic [17:0] a1;
    logic [35:0] a2;
    logic [17:0] b1;
    logic [17:0] b2;
    logic [1:0]  as;
    logic [53:0] cs;
    logic [53:0] res;
  } dmac_row_s;
  logic MCLK, RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, LOAD_SHIFT;
  logic ACC_LOAD;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, FLAGS;
  logic [3:0]  hs;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [3:0]  S_AXI_WSTRB, CLK_TICK, STAGE_CE, STAGE_RST, OPCODE;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, ADDSUB, rs;
  logic [17:0] OPERAND_A_FIRST, OPERAND_B_FIRST, OPERAND_B_SECOND, fab_val;
  logic [17:0] SHIFT_IN_A_FIRST, SHIFT_IN_B_FIRST, SHIFT_IN_B_SECOND, SHIFT_OUT_A_FIRST;
  logic [35:0] OPERAND_A_SECOND, SHIFT_IN_A_SECOND;
  logic [53:0] ACC_INIT, CASC_IN, RESULT, casc_v;
  dmac_row_s   rows [6];
  int          err_total;
  int          checks;
  dmac_slice dut (.MCLK, .RESETN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .CLK_TICK, .STAGE_CE, .STAGE_RST, .OPCODE, .ADDSUB, .LOAD_SHIFT, .ACC_LOAD,
    .ACC_INIT, .OPERAND_A_FIRST, .OPERAND_A_SECOND, .OPERAND_B_FIRST, .OPERAND_B_SECOND,
    .SHIFT_IN_A_FIRST, .SHIFT_IN_A_SECOND, .SHIFT_IN_B_FIRST, .SHIFT_IN_B_SECOND,
    .SHIFT_OUT_A_FIRST, .SHIFT_OUT_A_SECOND(), .SHIFT_OUT_B_FIRST(), .SHIFT_OUT_B_SECOND(),
    .CASC_IN, .CASC_OUT(), .RESULT, .PRODUCT(), .FLAGS);
  assign hs = {S_AXI_RVALID, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_AWREADY};
  dmac_fabric fab (.clk(MCLK), .load_val(fab_val), .casc_val(casc_v), .shift_a1(SHIFT_IN_A_FIRST),
    .shift_a2(SHIFT_IN_A_SECOND), .shift_b1(SHIFT_IN_B_FIRST), .shift_b2(SHIFT_IN_B_SECOND),
    .casc(CASC_IN));
  task automatic chk(input string nm, input logic [53:0] e, input logic [53:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Sampled at the falling edge: inputs only move at rising edges
  task automatic wait_hi(input int k);
    int n;
    @(negedge MCLK);
    for (n = 0; n < 50 && hs[k] !== 1'b1; n++)
      @(negedge MCLK);
    if (n == 50) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= wr;
    S_AXI_WVALID <= wr;
    S_AXI_BREADY <= wr;
    S_AXI_ARVALID <= !wr;
    S_AXI_RREADY <= !wr;
    wait_hi(wr ? 0 : 1);
    @(posedge MCLK);
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} <= 3'h0;
    wait_hi(wr ? 2 : 3);
    rd = S_AXI_RDATA;
    rs = wr ? S_AXI_BRESP : S_AXI_RRESP;
    @(posedge MCLK);
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  initial begin
    {RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {LOAD_SHIFT, ACC_LOAD, STAGE_RST, OPCODE, ADDSUB, ACC_INIT, casc_v, fab_val} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, OPERAND_A_FIRST, OPERAND_A_SECOND} = '0;
    {OPERAND_B_FIRST, OPERAND_B_SECOND, err_total, checks} = '0;
    {S_AXI_WSTRB, CLK_TICK, STAGE_CE} = 12'hFFF;
    rows = '{'{32'h20900, 18'h3FFFF, 36'hF_FFFF_FFFF, 0, 0, 0, 0, 54'h3F_FFEF_FFFC_0001},
      '{32'h20940, 18'h2, 36'h3, 0, 0, 0, 54'h40000, 54'h7},
      '{32'h2090B, 18'h100, 36'h200, 18'h7, 18'h9, 2'h0, 0, 54'h2003F},
      '{32'h2090B, 18'h100, 36'h200, 18'h7, 18'h9, 2'h1, 0, 54'h1FFC1},
      '{32'h2090C, 18'h5, 36'h6, 18'h2, 18'h3, 2'h2, 54'hA, 54'h1A},
      '{32'h2090C, 18'h5, 36'h6, 18'h2, 18'h3, 2'h0, 54'h1000, 54'h1024}};
    repeat (20) @(posedge MCLK);
    RESETN <= 1'b1;
    axi(0, ADDR_STAGE, 0);
    chk("stage", STAGE_INIT, rd);
    axi(0, 8'h40, 0);
    chk("rresp", RESP_SLVERR, rs);
    axi(1, ADDR_STAGE, 0);
    foreach (rows[i]) begin
      axi(1, ADDR_CFG, rows[i].cfg);
      {OPERAND_A_FIRST, OPERAND_A_SECOND} <= {rows[i].a1, rows[i].a2};
      {OPERAND_B_FIRST, OPERAND_B_SECOND} <= {rows[i].b1, rows[i].b2};
      ADDSUB <= rows[i].as;
      casc_v <= rows[i].cs;
      @(negedge MCLK);
      chk("result", rows[i].res, RESULT);
    end
    @(posedge MCLK);
    OPCODE <= 4'h5;
    @(negedge MCLK);
    chk("xor", 54'h18, RESULT);
    // Tree sum driven below zero raises under and the combined flag
    @(posedge MCLK);
    {OPCODE, ADDSUB} <= {4'h0, 2'h3};
    @(negedge MCLK);
    chk("flags", 8'hC0, FLAGS);
    // Only the output stage runs, so each edge adds one product
    axi(1, ADDR_STAGE, 32'h10000);
    axi(1, ADDR_CFG, 32'h20901);
    {OPERAND_A_FIRST, OPERAND_A_SECOND, ADDSUB} <= {18'h3, 36'h5, 2'h0};
    {ACC_INIT, ACC_LOAD} <= {54'h64, 1'b1};
    @(posedge MCLK);
    ACC_LOAD <= 1'b0;
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    chk("acc", 54'h91, RESULT);
    @(posedge MCLK);
    STAGE_CE <= 4'h0;
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    chk("hold", 54'hA0, RESULT);
    axi(0, ADDR_RES_LO, 0);
    chk("res_lo", 54'hA0, rd);
    STAGE_RST <= 4'h1;
    @(posedge MCLK);
    STAGE_RST <= 4'h0;
    @(negedge MCLK);
    chk("clear", 54'h0, RESULT);
    axi(1, ADDR_STAGE, 32'h1);
    {fab_val, LOAD_SHIFT, STAGE_CE} <= {18'h2AAAA, 1'b1, 4'hF};
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    chk("shift", 54'h2AAAA, SHIFT_OUT_A_FIRST);
    @(posedge MCLK);
    {LOAD_SHIFT, OPERAND_A_FIRST} <= {1'b0, 18'h155};
    @(posedge MCLK);
    @(negedge MCLK);
    chk("load", 54'h155, SHIFT_OUT_A_FIRST);
    @(posedge MCLK);
    RESETN <= 1'b0;
    @(posedge MCLK);
    RESETN <= 1'b1;
    axi(0, ADDR_CFG, 0);
    chk("cfg", CFG_RST, rd);
    test_done();
  end
endmodule
`default_nettype wire
